// *** design/disp_pkg.sv ***
// Contract
// - Device shifts serial out on clock fall
// - Device captures serial in on clock rise
// - Select high means data, low command
// - Nine-bit three-wire or eight-bit four-wire words
// - Transfers only while chip select low
// - Reset low returns device to initial state
// - Host resets device before any traffic
// - Up to 24-bit bus, unused lines grounded
// - Pixels accepted only while enable asserted
// - Host supplies pixel clock for sampling
// - Host pulses line sync once per row
// - Host pulses frame sync once per frame
// - Frame is 480 pixels by 854 lines
// - Depths of 16, 18, 24 bits per pixel
// - Host ties unused control inputs fixed; host drives data_command_select from SEND_IS_DATA in three-wire mode
package disp_pkg;
  localparam int H_ACTIVE = 480;
  localparam int V_ACTIVE = 854;
  localparam int BUS_W = 24;
  localparam int CNT_W = 10;
  localparam int SER_BITS_3W = 9;
  localparam int SER_BITS_4W = 8;
  localparam int DIV_HALF = 4;
  localparam logic [1:0] DEPTH_16 = 2'h0;
  localparam logic [1:0] DEPTH_18 = 2'h1;
  localparam logic [1:0] DEPTH_24 = 2'h2;

  function automatic logic [BUS_W-1:0] depth_mask(input logic [1:0] d);
    unique case (d)
      DEPTH_16: depth_mask = 24'h00ffff;
      DEPTH_18: depth_mask = 24'h03ffff;
      default: depth_mask = 24'hffffff;
    endcase
  endfunction : depth_mask
endpackage : disp_pkg

// *** design/disp_link_if.sv ***
`timescale 1ns/1ps
interface disp_link_if;
  logic reset_n;
  logic cs_n;
  logic sclk;
  logic data_command_select;
  logic serial_data_in;
  logic serial_data_out;
  logic pixel_clock;
  logic pixel_data_enable;
  logic hsync;
  logic vsync;
  logic [23:0] pixel_data_bus;
  modport device (input reset_n, cs_n, sclk, data_command_select, serial_data_in,
    pixel_clock, pixel_data_enable, hsync, vsync, pixel_data_bus, output serial_data_out);
  modport host (output reset_n, cs_n, sclk, data_command_select, serial_data_in,
    pixel_clock, pixel_data_enable, hsync, vsync, pixel_data_bus, input serial_data_out);
endinterface : disp_link_if

// *** design/disp_device.sv ***
`timescale 1ns/1ps
module disp_device
  import disp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  disp_link_if.device LINK,
  input wire logic FOUR_WIRE,
  input wire logic [1:0] DEPTH,
  input wire logic [7:0] READ_DATA,
  output logic WORD_VALID,
  output logic WORD_IS_DATA,
  output logic [7:0] WORD,
  output logic PIXEL_VALID,
  output logic [BUS_W-1:0] PIXEL,
  output logic [CNT_W-1:0] PIXEL_X,
  output logic [CNT_W-1:0] PIXEL_Y,
  output logic FRAME_START
);
  // ==========================================
  // Pin synchronisers: three stages, edge seen when 2nd and 3rd differ
  logic [2:0] rst_s, cs_s, sck_s, dc_s, sdi_s, pck_s, de_s, hs_s, vs_s;
  logic [BUS_W-1:0] bus_s1, bus_s2;
  always_ff @(posedge CORE_CLK) begin
    rst_s <= {rst_s[1:0], LINK.reset_n};
    cs_s <= {cs_s[1:0], LINK.cs_n};
    sck_s <= {sck_s[1:0], LINK.sclk};
    dc_s <= {dc_s[1:0], LINK.data_command_select};
    sdi_s <= {sdi_s[1:0], LINK.serial_data_in};
    pck_s <= {pck_s[1:0], LINK.pixel_clock};
    de_s <= {de_s[1:0], LINK.pixel_data_enable};
    hs_s <= {hs_s[1:0], LINK.hsync};
    vs_s <= {vs_s[1:0], LINK.vsync};
    bus_s1 <= LINK.pixel_data_bus;
    bus_s2 <= bus_s1;
  end
  // Bus is sampled a full stage later than the pixel clock edge is seen, so it is stable
  logic [BUS_W-1:0] bus_s3;
  always_ff @(posedge CORE_CLK) bus_s3 <= bus_s2;

  logic soft_rst;
  assign soft_rst = RST | ~rst_s[2];
  logic sck_rise, sck_fall, pck_rise, sel;
  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign sck_fall = ~sck_s[1] & sck_s[2];
  assign pck_rise = pck_s[1] & ~pck_s[2];
  assign sel = ~cs_s[2];

  // ==========================================
  // Serial receiver
  logic [3:0] bit_cnt_reg;
  logic [8:0] shift_reg;
  logic [3:0] word_len;
  assign word_len = FOUR_WIRE ? 4'(SER_BITS_4W) : 4'(SER_BITS_3W);
  always_ff @(posedge CORE_CLK) begin
    WORD_VALID <= 1'b0;
    if (soft_rst || !sel) begin
      bit_cnt_reg <= 4'h0;
      if (soft_rst) begin
        shift_reg <= 9'h000;
        WORD <= 8'h00;
        WORD_IS_DATA <= 1'b0;
      end
    end else if (sck_rise) begin
      shift_reg <= {shift_reg[7:0], sdi_s[2]};
      if (bit_cnt_reg == word_len - 4'h1) begin
        bit_cnt_reg <= 4'h0;
        WORD_VALID <= 1'b1;
        WORD <= {shift_reg[6:0], sdi_s[2]};
        WORD_IS_DATA <= FOUR_WIRE ? dc_s[2] : shift_reg[7];
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  // Read-back shifter: loads while deselected, shifts on falling edges.
  // Eight-bit words have no flag bit ahead of the payload, so their MSB goes out at select time
  logic [7:0] out_reg;
  logic lead_reg;
  always_ff @(posedge CORE_CLK) begin
    if (soft_rst || !sel) begin
      out_reg <= READ_DATA;
      LINK.serial_data_out <= 1'b0;
      lead_reg <= FOUR_WIRE;
    end else if (lead_reg) begin
      LINK.serial_data_out <= out_reg[7];
      out_reg <= {out_reg[6:0], out_reg[7]};
      lead_reg <= 1'b0;
    end else if (sck_fall) begin
      LINK.serial_data_out <= out_reg[7];
      out_reg <= {out_reg[6:0], out_reg[7]};
    end
  end

  // ==========================================
  // RGB receiver
  logic hs_d, vs_d;
  always_ff @(posedge CORE_CLK) begin
    PIXEL_VALID <= 1'b0;
    FRAME_START <= 1'b0;
    if (soft_rst) begin
      PIXEL <= '0;
      PIXEL_X <= '0;
      PIXEL_Y <= '0;
      hs_d <= 1'b0;
      vs_d <= 1'b0;
    end else if (pck_rise) begin
      hs_d <= hs_s[2];
      vs_d <= vs_s[2];
      if (vs_s[2] && !vs_d) begin
        PIXEL_Y <= '0;
        PIXEL_X <= '0;
        FRAME_START <= 1'b1;
      end else if (hs_s[2] && !hs_d) begin
        PIXEL_X <= '0;
        if (PIXEL_X != '0 && PIXEL_Y != CNT_W'(V_ACTIVE - 1)) PIXEL_Y <= PIXEL_Y + 1'b1;
      end else if (de_s[2] && PIXEL_X != CNT_W'(H_ACTIVE)) begin
        PIXEL_VALID <= 1'b1;
        PIXEL <= bus_s3 & depth_mask(DEPTH);
        PIXEL_X <= PIXEL_X + 1'b1;
      end
    end
  end
endmodule : disp_device

// *** design/disp_host.sv ***
`timescale 1ns/1ps
module disp_host
  import disp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  disp_link_if.host LINK,
  input wire logic FOUR_WIRE,
  input wire logic [1:0] DEPTH,
  input wire logic SEND,
  input wire logic SEND_IS_DATA,
  input wire logic [7:0] SEND_WORD,
  output logic SEND_READY,
  output logic [7:0] READ_WORD,
  input wire logic VIDEO_ON,
  input wire logic [BUS_W-1:0] PIXEL_IN,
  output logic PIXEL_TAKE
);
  typedef enum logic [1:0] {S_RESET = 2'b00, S_IDLE = 2'b01, S_SHIFT = 2'b11, S_END = 2'b10} ser_state_t;
  ser_state_t state_reg;
  logic [2:0] div_reg;
  logic tick;
  logic [3:0] bit_cnt_reg;
  logic [8:0] tx_reg;
  logic [7:0] rx_reg;
  logic [2:0] so_s;
  logic [8:0] load_word;
  assign tick = div_reg == 3'(DIV_HALF - 1);
  assign SEND_READY = state_reg == S_IDLE;
  assign load_word = FOUR_WIRE ? {SEND_WORD, 1'b0} : {SEND_IS_DATA, SEND_WORD};

  always_ff @(posedge CORE_CLK) begin
    if (RST || div_reg == 3'(DIV_HALF - 1)) div_reg <= 3'h0;
    else div_reg <= div_reg + 3'h1;
  end
  always_ff @(posedge CORE_CLK) so_s <= {so_s[1:0], LINK.serial_data_out};

  // ==========================================
  // Serial sender; a reset pulse is issued before any traffic
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_reg <= S_RESET;
      LINK.reset_n <= 1'b0;
      LINK.cs_n <= 1'b1;
      LINK.sclk <= 1'b0;
      LINK.serial_data_in <= 1'b0;
      LINK.data_command_select <= 1'b0;
      bit_cnt_reg <= 4'h0;
      tx_reg <= 9'h000;
      rx_reg <= 8'h00;
      READ_WORD <= 8'h00;
    end else if (tick) begin
      unique case (state_reg)
        S_RESET: begin
          LINK.reset_n <= 1'b1;
          state_reg <= S_IDLE;
        end
        S_IDLE: if (SEND) begin
          LINK.cs_n <= 1'b0;
          LINK.data_command_select <= SEND_IS_DATA;
          LINK.serial_data_in <= load_word[8];
          tx_reg <= {load_word[7:0], 1'b0};
          bit_cnt_reg <= FOUR_WIRE ? 4'(SER_BITS_4W) : 4'(SER_BITS_3W);
          state_reg <= S_SHIFT;
        end
        S_SHIFT: begin
          if (!LINK.sclk) begin
            LINK.sclk <= 1'b1;
          end else begin
            // Data moves on the fall so it has stood a half period at the next rise
            LINK.sclk <= 1'b0;
            LINK.serial_data_in <= tx_reg[8];
            tx_reg <= {tx_reg[7:0], 1'b0};
            rx_reg <= {rx_reg[6:0], so_s[2]}; // bit launched after the previous fall
            bit_cnt_reg <= bit_cnt_reg - 4'h1;
            if (bit_cnt_reg == 4'h1) state_reg <= S_END;
          end
        end
        S_END: begin
          LINK.cs_n <= 1'b1;
          READ_WORD <= rx_reg;
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // RGB sender: pixel clock is CORE_CLK divided by eight
  logic [CNT_W-1:0] x_reg, y_reg;
  logic frame_first_reg;
  logic pixel_slot;
  // Sync and blank periods consume no pixel, so the take pulse must skip them
  assign pixel_slot = !frame_first_reg && x_reg < CNT_W'(H_ACTIVE) && (x_reg != '0 || LINK.hsync);
  assign PIXEL_TAKE = tick && LINK.pixel_clock && VIDEO_ON && pixel_slot;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      LINK.pixel_clock <= 1'b0;
      LINK.pixel_data_enable <= 1'b0;
      LINK.hsync <= 1'b0;
      LINK.vsync <= 1'b0;
      LINK.pixel_data_bus <= '0;
      x_reg <= '0;
      y_reg <= '0;
      frame_first_reg <= 1'b1;
    end else if (tick) begin
      LINK.pixel_clock <= ~LINK.pixel_clock;
      if (LINK.pixel_clock) begin
        LINK.hsync <= 1'b0;
        LINK.vsync <= 1'b0;
        LINK.pixel_data_enable <= 1'b0;
        LINK.pixel_data_bus <= '0;
        if (!VIDEO_ON) begin
          x_reg <= '0;
          y_reg <= '0;
          frame_first_reg <= 1'b1;
        end else if (frame_first_reg) begin
          LINK.vsync <= 1'b1;
          frame_first_reg <= 1'b0;
        end else if (x_reg == CNT_W'(H_ACTIVE)) begin
          x_reg <= '0;
          if (y_reg == CNT_W'(V_ACTIVE - 1)) begin
            y_reg <= '0;
            frame_first_reg <= 1'b1;
          end else begin
            y_reg <= y_reg + 1'b1;
          end
        end else if (x_reg == '0 && !LINK.hsync) begin
          LINK.hsync <= 1'b1;
        end else begin
          LINK.pixel_data_enable <= 1'b1;
          LINK.pixel_data_bus <= PIXEL_IN & depth_mask(DEPTH);
          x_reg <= x_reg + 1'b1;
        end
      end
    end
  end
endmodule : disp_host

// *** tb/disp_props.sv ***
`timescale 1ns/1ps
module disp_props (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic data_command_select,
  input wire logic serial_data_in,
  input wire logic pixel_clock,
  input wire logic pixel_data_enable,
  input wire logic hsync,
  input wire logic vsync,
  input wire logic [23:0] pixel_data_bus
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  // ====================
  // Serial framing and pixel timing
  logic sclk_reg;
  logic [3:0] rises_reg;
  always_ff @(posedge CORE_CLK) begin
    sclk_reg <= sclk;
  end
  always_ff @(posedge CORE_CLK) begin
    if (RST || cs_n) begin
      rises_reg <= 4'h0;
    end else if (sclk && !sclk_reg) begin
      rises_reg <= rises_reg + 4'h1;
    end
  end
  sequence s_half_high;
    pixel_clock [*4] ##1 !pixel_clock;
  endsequence
  sequence s_one_pixel(sig);
    sig [*8] ##1 !sig;
  endsequence
  a_reset_first:
    assert property ($fell(RST) |-> !reset_n && cs_n ##[1:8] reset_n) else $error("link reset not issued");
  a_idle_sclk:
    assert property (cs_n |-> !sclk) else $error("serial clock moves while deselected");
  a_sdi_stable:
    assert property (sclk |-> $stable(serial_data_in)) else $error("data in moved while clock high");
  a_dc_stable:
    assert property (!cs_n && $past(!cs_n) |-> $stable(data_command_select)) else $error("select moved in word");
  a_word_len:
    assert property ($rose(cs_n) |-> rises_reg == 4'h8 || rises_reg == 4'h9) else $error("bad word length");
  a_pclk_half:
    assert property ($rose(pixel_clock) |-> s_half_high) else $error("pixel clock half period wrong");
  a_hsync_width:
    assert property ($rose(hsync) |-> s_one_pixel(hsync)) else $error("line sync width wrong");
  a_sync_no_de:
    assert property (hsync || vsync |-> !pixel_data_enable) else $error("enable during sync");
endmodule : disp_props

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import disp_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic four_wire = 1'b0;
  logic [1:0] depth = DEPTH_24;
  logic [7:0] read_data = 8'h00;
  logic send = 1'b0;
  logic send_is_data = 1'b0;
  logic [7:0] send_word = 8'h00;
  logic video_on = 1'b0;
  logic [BUS_W-1:0] pixel_in = 24'hfedcba;
  logic [BUS_W-1:0] mask = 24'hffffff;
  logic word_valid, word_is_data, pixel_valid, frame_start, send_ready, pixel_take;
  logic [7:0] word, read_word;
  logic [BUS_W-1:0] pixel;
  logic [CNT_W-1:0] pixel_x, pixel_y;
  logic [BUS_W-1:0] q[$];
  int n_mismatch = 0, checked = 0, lx = 0, ly = 0, frames = 0;
  disp_link_if link();
  disp_device i_disp_device (.CORE_CLK(clk), .RST(rst), .LINK(link), .FOUR_WIRE(four_wire), .DEPTH(depth),
    .READ_DATA(read_data), .WORD_VALID(word_valid), .WORD_IS_DATA(word_is_data), .WORD(word),
    .PIXEL_VALID(pixel_valid), .PIXEL(pixel), .PIXEL_X(pixel_x), .PIXEL_Y(pixel_y), .FRAME_START(frame_start));
  disp_host i_disp_host (.CORE_CLK(clk), .RST(rst), .LINK(link), .FOUR_WIRE(four_wire), .DEPTH(depth),
    .SEND(send), .SEND_IS_DATA(send_is_data), .SEND_WORD(send_word), .SEND_READY(send_ready),
    .READ_WORD(read_word), .VIDEO_ON(video_on), .PIXEL_IN(pixel_in), .PIXEL_TAKE(pixel_take));
  disp_props i_disp_props (.CORE_CLK(clk), .RST(rst), .reset_n(link.reset_n), .cs_n(link.cs_n), .sclk(link.sclk),
    .data_command_select(link.data_command_select), .serial_data_in(link.serial_data_in),
    .pixel_clock(link.pixel_clock), .pixel_data_enable(link.pixel_data_enable), .hsync(link.hsync),
    .vsync(link.vsync), .pixel_data_bus(link.pixel_data_bus));
  always #10 clk = ~clk;
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic results();
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  function automatic logic flag(input int k);
    return k == 0 ? send_ready : word_valid;
  endfunction : flag
  // ====================
  // Serial words
  task automatic wait_for(input int k, input logic lvl);
    int n;
    n = 0;
    while (flag(k) !== lvl && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("handshake", {23'h0, lvl}, {23'h0, flag(k)});
  endtask : wait_for
  task automatic word_xfer(input logic fw, input logic dc, input logic [7:0] w, input logic [7:0] rd);
    four_wire <= fw;
    read_data <= rd;
    send_is_data <= dc;
    send_word <= w;
    send <= 1'b1;
    wait_for(0, 1'b0);
    @(posedge clk);
    send <= 1'b0;
    wait_for(1, 1'b1);
    chk("word", {16'h0, w}, {16'h0, word});
    chk("word_is_data", {23'h0, dc}, {23'h0, word_is_data});
    wait_for(0, 1'b1);
    chk("read_word", {16'h0, rd}, {16'h0, read_word});
    @(posedge clk);
  endtask : word_xfer
  // ====================
  // Pixel stream; each run starts with a reset, the second and third in mid-frame
  task automatic video(input logic [1:0] d, input logic [BUS_W-1:0] m);
    rst <= 1'b1;
    video_on <= 1'b0;
    depth <= d;
    mask <= m;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    video_on <= 1'b1;
    repeat (6000) @(posedge clk);
  endtask : video
  always @(posedge clk) begin
    if (q.size() != 0 && q[$] === pixel_in) pixel_in <= pixel_in + 24'h9e3779;
  end
  // Sampled at the falling edge so the combinational take pulse has settled
  always @(negedge clk) begin
    if (rst) begin
      q.delete();
      lx = 0;
      ly = 0;
    end else begin
      if (frame_start) begin
        lx = 0;
        ly = 0;
        frames++;
      end
      if (link.pixel_data_enable === 1'b1) chk("unused_lines", 24'h0, link.pixel_data_bus & ~mask);
      if (pixel_take === 1'b1) q.push_back(pixel_in);
      if (pixel_valid === 1'b1) begin
        chk("pixel", q.pop_front() & mask, pixel);
        chk("pixel_x", 24'(lx + 1), {14'h0, pixel_x});
        chk("pixel_y", 24'(ly), {14'h0, pixel_y});
        lx++;
        if (lx == H_ACTIVE) begin
          lx = 0;
          ly++;
        end
      end
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_for(0, 1'b1);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      word_xfer(i[1], i[0], 8'h96 ^ (8'h3c * i[7:0]), 8'h5e + 8'h21 * i[7:0]);
    end
    video(DEPTH_16, 24'h00ffff);
    video(DEPTH_18, 24'h03ffff);
    video(DEPTH_24, 24'hffffff);
    chk("frames", 24'h3, 24'(frames));
    chk("lines", 24'h1, 24'(ly));
    results();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule : tb_top
